// ===== core/hpru_consts.vh
// Purpose: constants for the hibernation power and rtc unit
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef HPRU_CONSTS_VH
`define HPRU_CONSTS_VH

// register byte offsets
`define HPRU_OFF_COUNT      12'h000
`define HPRU_OFF_MATCH_A    12'h004
`define HPRU_OFF_MATCH_B    12'h008
`define HPRU_OFF_LOAD       12'h00c
`define HPRU_OFF_CTRL       12'h010
`define HPRU_OFF_MASK       12'h014
`define HPRU_OFF_RAW        12'h018
`define HPRU_OFF_MSTAT      12'h01c
`define HPRU_OFF_CLEAR      12'h020
`define HPRU_OFF_TRIM       12'h024
`define HPRU_OFF_MEM_LO     12'h030
`define HPRU_OFF_MEM_HI     12'h12c

// control bit positions
`define HPRU_CTL_RTC_EN     0
`define HPRU_CTL_HIB_REQ    1
`define HPRU_CTL_CLK_SEL    2
`define HPRU_CTL_RTC_WEN    3
`define HPRU_CTL_PIN_WEN    4
`define HPRU_CTL_LB_EN      5
`define HPRU_CTL_CLK_EN     6
`define HPRU_CTL_LB_ABORT   7
`define HPRU_CTL_WIDTH      8

// event bit positions
`define HPRU_EV_MATCH_A     0
`define HPRU_EV_MATCH_B     1
`define HPRU_EV_LOW_BAT     2
`define HPRU_EV_WAKE        3
`define HPRU_EV_WIDTH       4

// reset values
`define HPRU_RST_MATCH      32'hffffffff
`define HPRU_RST_LOAD       32'hffffffff
`define HPRU_RST_TRIM       16'h7fff
`define HPRU_NOM_DIV        16'h7fff

// timing: index of the second that gets the trim, once in 64; crystal divider
`define HPRU_TRIM_PERIOD    6'h3f
`define HPRU_XTAL_DIV       7'h7f

`endif

// ===== core/hpru_unit.v
// Purpose: hibernation power sequencer with rtc and retained memory
// Assumes: apb slave on clk; slow clock pins sampled through 2 flops
// Notes:   32.768 khz tick derived from sampled clock source edges
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "hpru_consts.vh"

// Functional notes
// RULE_01 - asserted regulator output turns regulator off
// RULE_02 - hibernate request bit enters hibernation
// RULE_03 - software configures a wake source first
// RULE_04 - wake pin or match restores power
// RULE_05 - pin wake needs pin wake enable
// RULE_06 - match wake needs rtc wake enable
// RULE_07 - software spaces writes in slow domain
// RULE_08 - back to back reads always accepted
// RULE_09 - clock source runs only when enabled
// RULE_10 - select 0 divides by 128, 1 direct
// RULE_11 - software waits crystal settling time
// RULE_12 - detect battery below threshold, may interrupt
// RULE_13 - detect enable sets low battery flag
// RULE_14 - abort bit blocks hibernation on low battery
// RULE_15 - battery not measured while hibernating
// RULE_16 - 32 bit counter ticks once per second
// RULE_17 - trim divisor used one second in 64
// RULE_18 - larger trim slows, smaller trim speeds
// RULE_19 - two matches wake or interrupt
// RULE_20 - counter runs if enabled; load anytime
// RULE_21 - 64 retained words readable and writable
// RULE_22 - wake cause visible in raw status
// RULE_23 - event sources ored into one request
// RULE_24 - wake pin active low, synchronised
module hpru_unit
(
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clkEn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // clock source pins
    input  wire        xtalClkIn,
    input  wire        oscClkIn,
    output reg         clockSourceOn,
    // power and wake pins
    input  wire        wake_n,
    input  wire        batteryLow,
    output reg         regulator_off_n,
    output reg         eventIrq
);

    // pin synchronisers, first stage read only by the second
    reg [3:0] syncA_reg;       // stage one
    reg [3:0] syncB_reg;       // stage two, safe to use
    reg       slowPrev_reg;    // previous selected clock level
    reg       wakePrev_reg;    // previous wake level for edge
    // edge history for the crystal and the late second tick
    reg       slowPrevX;       // previous crystal level
    reg       secTickD;        // second tick, one cycle late
    reg [6:0] xtalDiv_reg;     // crystal divide-by-128 counter

    // registers
    reg [31:0] counter_reg;    // rtc seconds
    reg [31:0] matchA_reg;     // rtc_match_a
    reg [31:0] matchB_reg;     // rtc_match_b
    reg [31:0] load_reg;       // rtc_load_value
    reg [`HPRU_CTL_WIDTH-1:0] ctrl_reg;  // hibernate_control
    reg [`HPRU_EV_WIDTH-1:0]  mask_reg;  // event mask
    reg [`HPRU_EV_WIDTH-1:0]  raw_reg;   // raw_event_status
    reg [15:0] trim_reg;       // predivider_trim
    reg [15:0] prediv_reg;     // predivider down counter
    reg [5:0]  secCnt_reg;     // which second of 64
    reg        hib_reg;        // hibernating state
    reg [31:0] memory_reg [0:63];   // retained_memory

    // one-hot power states
    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_HIB = 2'b10;
    reg [1:0] state_reg;
    reg [1:0] state_next;

    // decoded helpers
    wire        xtalS   = syncB_reg[0];
    wire        oscS    = syncB_reg[1];
    wire        wakeAct = ~syncB_reg[2];
    wire        lowBatS = syncB_reg[3];
    wire        access  = psel & penable & clkEn;
    wire        wrEn    = access & pwrite;
    wire        rdEn    = access & ~pwrite;
    wire        memHit;
    wire [5:0]  memIdx;
    wire        slowLvl;
    wire        slowTick;
    wire        secTick;
    wire        hitA;
    wire        hitB;
    wire        wakeGo;
    wire [15:0] divSel;
    wire [`HPRU_EV_WIDTH-1:0] evSet;
    wire [`HPRU_EV_WIDTH-1:0] clrBits;

    // decode an address against a register offset, used many times
    function sel;
        input [11:0] a;
        input [11:0] off;
        begin
            sel = (a == off);
        end
    endfunction

    // retained memory window; address bits 7:2 after base subtract
    assign memHit = (paddr >= `HPRU_OFF_MEM_LO)
                  & (paddr <= `HPRU_OFF_MEM_HI)
                  & (paddr[1:0] == 2'h0);
    assign memIdx = paddr[7:2] - 6'h0c;

    // sample every slow pin through two flops
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            syncA_reg <= 4'h4;
            syncB_reg <= 4'h4;
        end
        else if (clkEn)
        begin
            syncA_reg <= {batteryLow, wake_n, oscClkIn, xtalClkIn};
            syncB_reg <= syncA_reg;
        end
    end

    // RULE_10 crystal divided by 128, rising crystal edges only;
    // counting both edges would halve the divide and run the
    // rtc twice as fast
    always @(posedge clk)
    begin
        if (!rst_n)
            xtalDiv_reg <= 7'h00;
        else if (clkEn && ctrl_reg[`HPRU_CTL_CLK_EN])
            xtalDiv_reg <= xtalDiv_reg
                         + {6'h00, (xtalS & ~slowPrevX)};
    end

    // previous crystal level for edge counting
    always @(posedge clk)
    begin
        if (!rst_n)
            slowPrevX <= 1'b0;
        else if (clkEn)
            slowPrevX <= xtalS;
    end

    // RULE_10 select divided crystal or direct oscillator
    assign slowLvl = ctrl_reg[`HPRU_CTL_CLK_SEL] ? oscS : xtalDiv_reg[6];

    // RULE_09 ticks only while clock source enabled
    assign slowTick = ctrl_reg[`HPRU_CTL_CLK_EN] & slowLvl & ~slowPrev_reg;

    // RULE_17 trim divisor on one second in 64; picked for the
    // second that starts at the next reload, so second 63 is trimmed
    assign divSel = (secCnt_reg + 6'h01 == `HPRU_TRIM_PERIOD)
                  ? trim_reg : `HPRU_NOM_DIV;
    // RULE_18 larger divisor gives a longer second
    assign secTick = slowTick & (prediv_reg == 16'h0000);

    // RULE_19 both match comparators
    assign hitA = (counter_reg == matchA_reg);
    assign hitB = (counter_reg == matchB_reg);

    // RULE_05 pin wake gated; RULE_06 match wake gated
    assign wakeGo = (ctrl_reg[`HPRU_CTL_PIN_WEN] & wakeAct)
                  | (ctrl_reg[`HPRU_CTL_RTC_WEN] & (hitA | hitB));

    // event sources; RULE_15 battery not measured in hibernation
    assign evSet[`HPRU_EV_MATCH_A] = hitA & secTickD;
    assign evSet[`HPRU_EV_MATCH_B] = hitB & secTickD;
    // RULE_13 low battery flag when detect enabled
    assign evSet[`HPRU_EV_LOW_BAT] = ctrl_reg[`HPRU_CTL_LB_EN]
                                   & lowBatS & ~hib_reg;
    // RULE_24 active low wake edge
    assign evSet[`HPRU_EV_WAKE]    = wakeAct & ~wakePrev_reg;
    assign clrBits = (wrEn && sel(paddr, `HPRU_OFF_CLEAR))
                   ? pwdata[`HPRU_EV_WIDTH-1:0] : {`HPRU_EV_WIDTH{1'b0}};

    // one cycle late second tick so matches see new count
    always @(posedge clk)
    begin
        if (!rst_n)
            secTickD <= 1'b0;
        else if (clkEn)
            secTickD <= secTick & ctrl_reg[`HPRU_CTL_RTC_EN];
    end

    // slow clock edge and wake history
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            slowPrev_reg <= 1'b0;
            wakePrev_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            slowPrev_reg <= slowLvl;
            wakePrev_reg <= wakeAct;
        end
    end

    // predivider and rtc counter
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            prediv_reg  <= `HPRU_NOM_DIV;
            secCnt_reg  <= 6'h00;
            counter_reg <= 32'h00000000;
        end
        else if (clkEn)
        begin
            // RULE_20 load sets counter at any time
            if (wrEn && sel(paddr, `HPRU_OFF_LOAD))
                counter_reg <= pwdata;
            // RULE_16 one increment per second when enabled
            else if (secTick && ctrl_reg[`HPRU_CTL_RTC_EN])
                counter_reg <= counter_reg + 32'h00000001;
            if (slowTick && ctrl_reg[`HPRU_CTL_RTC_EN])
            begin
                if (prediv_reg == 16'h0000)
                begin
                    // reload for the next second
                    secCnt_reg <= secCnt_reg + 6'h01;
                    // RULE_17 trimmed divisor for one second in 64
                    prediv_reg <= divSel;
                end
                else
                    prediv_reg <= prediv_reg - 16'h0001;
            end
        end
    end

    // power state machine
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
                // RULE_02 request enters; RULE_14 abort blocks it
                if (ctrl_reg[`HPRU_CTL_HIB_REQ]
                    && !(ctrl_reg[`HPRU_CTL_LB_ABORT]
                         && ctrl_reg[`HPRU_CTL_LB_EN] && lowBatS))
                    state_next = ST_HIB;
            ST_HIB:
                // RULE_04 wake restores power
                if (wakeGo)
                    state_next = ST_RUN;
            default:
                state_next = ST_RUN;
        endcase
    end

    // state, control and status registers
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg       <= ST_RUN;
            hib_reg         <= 1'b0;
            regulator_off_n <= 1'b1;
            ctrl_reg        <= {`HPRU_CTL_WIDTH{1'b0}};
            mask_reg        <= {`HPRU_EV_WIDTH{1'b0}};
            raw_reg         <= {`HPRU_EV_WIDTH{1'b0}};
            matchA_reg      <= `HPRU_RST_MATCH;
            matchB_reg      <= `HPRU_RST_MATCH;
            load_reg        <= `HPRU_RST_LOAD;
            trim_reg        <= `HPRU_RST_TRIM;
            eventIrq        <= 1'b0;
            clockSourceOn   <= 1'b0;
        end
        else if (clkEn)
        begin
            state_reg <= state_next;
            hib_reg   <= (state_next == ST_HIB);
            // RULE_01 low output switches regulator off
            regulator_off_n <= (state_next != ST_HIB);
            clockSourceOn   <= ctrl_reg[`HPRU_CTL_CLK_EN];
            // request bit self clears on wake so power-up runs
            if (wrEn && sel(paddr, `HPRU_OFF_CTRL))
                ctrl_reg <= pwdata[`HPRU_CTL_WIDTH-1:0];
            else if (state_reg == ST_HIB && state_next == ST_RUN)
                ctrl_reg[`HPRU_CTL_HIB_REQ] <= 1'b0;
            if (wrEn && sel(paddr, `HPRU_OFF_MASK))
                mask_reg <= pwdata[`HPRU_EV_WIDTH-1:0];
            if (wrEn && sel(paddr, `HPRU_OFF_MATCH_A))
                matchA_reg <= pwdata;
            if (wrEn && sel(paddr, `HPRU_OFF_MATCH_B))
                matchB_reg <= pwdata;
            if (wrEn && sel(paddr, `HPRU_OFF_LOAD))
                load_reg <= pwdata;
            if (wrEn && sel(paddr, `HPRU_OFF_TRIM))
                trim_reg <= pwdata[15:0];
            // RULE_22 sticky causes, set wins over clear
            raw_reg <= (raw_reg & ~clrBits) | evSet;
            // RULE_23 masked events ored into one request
            eventIrq <= |(((raw_reg & ~clrBits) | evSet) & mask_reg);
        end
    end

    // RULE_21 retained memory writes
    always @(posedge clk)
    begin
        if (clkEn && wrEn && memHit)
            memory_reg[memIdx] <= pwdata;
    end

    // apb answer: one wait-free access phase
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clkEn)
        begin
            // RULE_08 reads answered back to back
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite)
            begin
                if (memHit)
                    prdata <= memory_reg[memIdx];
                else if (sel(paddr, `HPRU_OFF_COUNT))
                    prdata <= counter_reg;
                else if (sel(paddr, `HPRU_OFF_MATCH_A))
                    prdata <= matchA_reg;
                else if (sel(paddr, `HPRU_OFF_MATCH_B))
                    prdata <= matchB_reg;
                else if (sel(paddr, `HPRU_OFF_LOAD))
                    prdata <= load_reg;
                else if (sel(paddr, `HPRU_OFF_CTRL))
                    prdata <= {24'h000000, ctrl_reg};
                else if (sel(paddr, `HPRU_OFF_MASK))
                    prdata <= {28'h0000000, mask_reg};
                else if (sel(paddr, `HPRU_OFF_RAW))
                    prdata <= {28'h0000000, raw_reg};
                else if (sel(paddr, `HPRU_OFF_MSTAT))
                    prdata <= {28'h0000000, raw_reg & mask_reg};
                else if (sel(paddr, `HPRU_OFF_TRIM))
                    prdata <= {16'h0000, trim_reg};
                else
                    prdata <= 32'h00000000;
            end
            // unmapped addresses answer with an error
            if (psel && !penable)
                pslverr <= !(memHit || paddr <= `HPRU_OFF_TRIM)
                           || paddr[1:0] != 2'h0
                           || (paddr > `HPRU_OFF_TRIM
                               && paddr < `HPRU_OFF_MEM_LO);
        end
    end

    // rdEn kept for readability of the access decode
    wire unusedRd = rdEn;

endmodule

// ===== dv/hpru_partner.sv
// Purpose: external regulator, wake button and clock sources
// Assumes: clock sources sped up so slow-domain events fit the run
// Notes:   the wake line has a pull-up, so released means high
`timescale 1ns/1ps
module hpru_partner
#(
    parameter int RAMP = 8  // regulator turn-on cycles
)
(
    // clock
    input  wire logic clk,
    // regulator and button
    input  wire logic regulator_off_n,
    input  wire logic wakePress,
    // outputs to the unit and bench
    output logic      wake_n,
    output logic      oscClkIn,
    output logic      xtalClkIn,
    output logic      supplyUp
);
    logic [2:0] div = 3'h0;  // free-running oscillator divider
    int         ramp = 0;    // turn-on progress
    initial supplyUp = 1'b0;
    // oscillators run free, unlike a link clock
    always @(posedge clk) div <= div + 3'h1;
    // oscillator toggles every clock so one rtc second fits the run
    assign oscClkIn  = div[0];
    assign xtalClkIn = div[1];
    // pull-up wins when the button is let go
    assign wake_n = wakePress ? 1'b0 : 1'b1;
    always @(posedge clk)
    begin
        if (!regulator_off_n)
        begin
            supplyUp <= 1'b0;
            ramp <= 0;
        end
        else if (ramp < RAMP)
        begin
            ramp <= ramp + 1;
        end
        else
        begin
            supplyUp <= 1'b1;
        end
    end
endmodule

// ===== dv/hpru_unit_properties.sv
// Purpose: port-level properties of the hibernation power and rtc unit
// Assumes: apb answer in the access cycle, single clock domain
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
`include "hpru_consts.vh"
module hpru_unit_properties
(
    // clock and reset
    input wire        clk,
    input wire        rst_n,
    input wire        clkEn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // pins
    input wire        xtalClkIn,
    input wire        oscClkIn,
    input wire        clockSourceOn,
    input wire        wake_n,
    input wire        batteryLow,
    input wire        regulator_off_n,
    input wire        eventIrq
);
    logic       ctlWr;      // completed control write
    logic       lastEn;     // last written enable bit
    logic [7:0] sinceReq;   // cycles since a hibernate request
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign ctlWr = psel && penable && pready && pwrite
        && paddr == `HPRU_OFF_CTRL;
    // saturating age so a late power cut has no cause
    always @(posedge clk)
    begin
        if (ctlWr)
        begin
            lastEn <= pwdata[`HPRU_CTL_CLK_EN];
        end
        if (!rst_n)
        begin
            sinceReq <= 8'hff;
        end
        else if (ctlWr && pwdata[`HPRU_CTL_HIB_REQ])
        begin
            sinceReq <= 8'h00;
        end
        else if (sinceReq != 8'hff)
        begin
            sinceReq <= sinceReq + 8'h01;
        end
    end
    a_reset_outputs: assert property ($rose(rst_n) |-> regulator_off_n
        && !eventIrq && !pready) else $error("outputs wrong after reset");
    a_access_answer: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (psel && !penable && !pwrite
        && (paddr == 12'h028 || paddr > 12'h12c) |=> pslverr && prdata == 0)
        else $error("unmapped read not refused");
    a_mem_mapped: assert property (psel && !penable && paddr >= 12'h030
        && paddr <= 12'h12c && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("memory word refused");
    a_clk_follow: assert property (ctlWr |=> ##1 clockSourceOn == lastEn)
        else $error("clock source enable not followed");
    a_hib_enter: assert property (ctlWr && pwdata[`HPRU_CTL_HIB_REQ]
        && pwdata[`HPRU_CTL_CLK_EN] && !batteryLow && wake_n
        |-> ##[1:200] !regulator_off_n) else $error("no hibernation");
    a_hib_cause: assert property ($fell(regulator_off_n) |-> sinceReq < 200)
        else $error("power cut without request");
    a_prdata_hold: assert property ($changed(prdata)
        |-> $past(psel && !penable && !pwrite)) else $error("read data moved");
endmodule
bind hpru_unit hpru_unit_properties hpru_unit_props_i (.clk(clk),
    .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xtalClkIn(xtalClkIn),
    .oscClkIn(oscClkIn), .clockSourceOn(clockSourceOn), .wake_n(wake_n),
    .batteryLow(batteryLow), .regulator_off_n(regulator_off_n),
    .eventIrq(eventIrq));

// ===== dv/tb.sv
// Purpose: self-checking bench for the hibernation power and rtc unit
// Assumes: apb answer waited for, never counted
// Notes:   slow-domain writes are spaced by the bench itself
`timescale 1ns/1ps
`include "hpru_consts.vh"
module tb;
    logic clk = 0, rst_n = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv, q1;
    logic pready, pslverr, errv, xtalClkIn, oscClkIn, clockSourceOn, wake_n;
    logic batteryLow = 0, regulator_off_n, eventIrq, wakePress = 0, supplyUp;
    int n_errors = 0, check_count = 0, cyc = 0;
    always #5 clk = ~clk;
    hpru_unit hpru_unit_i (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xtalClkIn(xtalClkIn), .oscClkIn(oscClkIn),
        .clockSourceOn(clockSourceOn), .wake_n(wake_n),
        .batteryLow(batteryLow), .regulator_off_n(regulator_off_n),
        .eventIrq(eventIrq));
    hpru_partner hpru_partner_i (.clk(clk),
        .regulator_off_n(regulator_off_n), .wakePress(wakePress),
        .wake_n(wake_n), .oscClkIn(oscClkIn), .xtalClkIn(xtalClkIn),
        .supplyUp(supplyUp));
    // compare and count
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, request left standing
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
    endtask
    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
        idle();
        repeat (20) @(posedge clk);
    endtask
    task automatic rd(logic [11:0] a);
        apb(1'b0, a, 32'h0);
        idle();
    endtask
    task automatic waitReg(logic lvl);
        for (int i = 0; i < 400 && regulator_off_n !== lvl; i++)
            @(posedge clk);
    endtask
    task automatic t_reset_values;
        logic [11:0] a [7] = '{12'h000, 12'h004, 12'h008, 12'h00c,
            12'h010, 12'h018, 12'h024};
        logic [31:0] e [7] = '{32'h0, 32'hffffffff, 32'hffffffff,
            32'hffffffff, 32'h0, 32'h0, 32'h00007fff};
        foreach (a[i])
        begin
            rd(a[i]);
            chk("reset value", e[i], rdv);
        end
        chk("regulator", 32'h1, {31'h0, regulator_off_n});
    endtask
    task automatic t_regs;
        wr(`HPRU_OFF_LOAD, 32'h12345678);
        rd(`HPRU_OFF_COUNT);
        chk("count", 32'h12345678, rdv);
        wr(`HPRU_OFF_TRIM, 32'h00008000);
        wr(`HPRU_OFF_MATCH_A, 32'ha5a5a5a5);
        wr(`HPRU_OFF_MATCH_B, 32'h5a5a5a5a);
        apb(1'b0, `HPRU_OFF_MATCH_A, 32'h0);
        q1 = rdv;
        apb(1'b0, `HPRU_OFF_MATCH_B, 32'h0);
        apb(1'b0, `HPRU_OFF_TRIM, 32'h0);
        idle();
        chk("match a", 32'ha5a5a5a5, q1);
        chk("trim", 32'h00008000, rdv);
        rd(12'h028);
        chk("unmapped", 32'h1, {31'h0, errv});
        chk("unmapped data", 32'h0, rdv);
    endtask
    task automatic t_memory;
        wr(`HPRU_OFF_MEM_LO, 32'hc0ffee01);
        wr(`HPRU_OFF_MEM_HI, 32'hc0ffee3f);
        rd(`HPRU_OFF_MEM_LO);
        chk("memory low", 32'hc0ffee01, rdv);
        rd(`HPRU_OFF_MEM_HI);
        chk("memory high", 32'hc0ffee3f, rdv);
    endtask
    task automatic t_pin_wake;
        wr(`HPRU_OFF_CTRL, 32'h00000044);
        chk("source on", 32'h1, {31'h0, clockSourceOn});
        wr(`HPRU_OFF_CTRL, 32'h0000007e);
        waitReg(1'b0);
        chk("hibernating", 32'h0, {31'h0, regulator_off_n});
        chk("supply off", 32'h0, {31'h0, supplyUp});
        // low battery while asleep must leave no flag
        batteryLow <= 1'b1;
        repeat (50) @(posedge clk);
        batteryLow <= 1'b0;
        repeat (20) @(posedge clk);
        wakePress <= 1'b1;
        waitReg(1'b1);
        chk("woken", 32'h1, {31'h0, regulator_off_n});
        wakePress <= 1'b0;
        repeat (20) @(posedge clk);
        chk("supply on", 32'h1, {31'h0, supplyUp});
        rd(`HPRU_OFF_RAW);
        chk("wake cause", 32'h8, rdv & 32'hc);
        wr(`HPRU_OFF_MASK, 32'h00000008);
        chk("irq", 32'h1, {31'h0, eventIrq});
        wr(`HPRU_OFF_CLEAR, 32'h00000008);
        chk("irq clear", 32'h0, {31'h0, eventIrq});
        rd(`HPRU_OFF_MEM_HI);
        chk("retained", 32'hc0ffee3f, rdv);
    endtask
    task automatic t_pin_disabled;
        wr(`HPRU_OFF_CTRL, 32'h0000004e);
        waitReg(1'b0);
        wakePress <= 1'b1;
        repeat (300) @(posedge clk);
        chk("no pin wake", 32'h0, {31'h0, regulator_off_n});
        wakePress <= 1'b0;
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(`HPRU_OFF_MEM_LO);
        chk("kept over reset", 32'hc0ffee01, rdv);
    endtask
    task automatic t_low_battery;
        batteryLow <= 1'b1;
        wr(`HPRU_OFF_CTRL, 32'h000000e4);
        rd(`HPRU_OFF_RAW);
        chk("low flag", 32'h4, rdv & 32'h4);
        wr(`HPRU_OFF_CTRL, 32'h000000f6);
        repeat (300) @(posedge clk);
        chk("abort", 32'h1, {31'h0, regulator_off_n});
    endtask
    task automatic t_rtc_wake;
        int n;
        wr(`HPRU_OFF_CTRL, 32'h00000044);
        batteryLow <= 1'b0;
        wr(`HPRU_OFF_MATCH_A, 32'h00000100);
        wr(`HPRU_OFF_LOAD, 32'h000000ff);
        wr(`HPRU_OFF_CTRL, 32'h0000004f);
        chk("rtc sleep", 32'h0, {31'h0, regulator_off_n});
        n = 0;
        while (n < 70000 && regulator_off_n !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        // one second is 32768 slow ticks of two clocks each
        chk("one second", 32'h1, {31'h0, n > 65000 && n < 66000});
        rd(`HPRU_OFF_COUNT);
        chk("count tick", 32'h00000100, rdv);
        rd(`HPRU_OFF_RAW);
        chk("match cause", 32'h1, rdv & 32'h3);
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // hang guard, well above the expected run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_regs();
        t_memory();
        t_pin_wake();
        t_pin_disabled();
        t_low_battery();
        t_rtc_wake();
        print_verdict();
    end
endmodule
